// *** verilog/ppg_pkg.sv ***
// Shared constants and types for the cascaded pulse generator
package ppg_pkg;

   // Bus geometry and answers
   localparam int         ADDR_W      = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] MODE_OFS    = 8'h04;
   localparam logic [7:0] PER_LO_OFS  = 8'h08;
   localparam logic [7:0] PER_HI_OFS  = 8'h0C;
   localparam logic [7:0] DUTY_LO_OFS = 8'h10;
   localparam logic [7:0] DUTY_HI_OFS = 8'h14;
   localparam logic [7:0] STAT_OFS    = 8'h18;

   // Field codes and reset values
   localparam logic [1:0]  MODE_PPG   = 2'h3;
   localparam logic [7:0]  TIMER_RST  = 8'hFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam int          CTRL_W     = 3;
   localparam int          MODE_W     = 10;
   localparam int          STAT_LVL   = 16;

   // Prescaler widths: system divider and low-frequency divider
   localparam int PRESC_W = 11;
   localparam int LF_W    = 4;

   // Pair control: bit2 pin function, bit1 run, bit0 cascade
   typedef struct packed {
      logic pin_function;
      logic run_bit;
      logic cascade_enable;
   } ctrl_type;

   // High-timer mode register layout, msb first
   typedef struct packed {
      logic       slow_mode;
      logic       prescaler_source_bit;
      logic       initial_level_bit;
      logic       double_buffer_enable;
      logic [2:0] clock_select_field;
      logic       external_input_select;
      logic [1:0] mode_field;
   } mode_type;

   // One set of compare values
   typedef struct packed {
      logic [15:0] period_value;
      logic [15:0] duty_value;
   } compare_type;

   localparam ctrl_type    CTRL_RST = '0;
   localparam mode_type    MODE_RST = '0;
   localparam compare_type CMP_RST  = '1;

endpackage

// *** verilog/edge_sync.sv ***
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Asynchronous level in, pulse out
   input  wire logic async_in,
   output logic      rise_q
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // Only sync_q reads meta_q; the edge uses the later stages
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
         rise_q <= sync_q & ~last_q;
      end
   end

endmodule
`default_nettype wire

// *** verilog/tick_source.sv ***
// Source clock selection and prescaler for the pulse counter
`timescale 1ns/1ps
`default_nettype none
module tick_source
   import ppg_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Selection fields
   input  wire logic [2:0] clock_select_field,
   input  wire logic       external_input_select,
   input  wire logic       prescaler_source_bit,
   input  wire logic       slow_mode,
   // Synchronised edges of the clock pins
   input  wire logic       lf_edge,
   input  wire logic       ext_edge,
   // One-cycle count enable
   output logic            tick_q
);

   logic [PRESC_W-1:0] presc_q;
   logic [LF_W-1:0]    lf_q;
   logic               lf_code;
   logic               sys_tick;
   logic               lf_tick;

   // System divisions 2^11,2^10,2^8,2^6,2^4,2^2,2,1
   function automatic logic [PRESC_W-1:0] sys_mask(input logic [2:0] c);
      case (c)
         3'h0:    sys_mask = 11'h7FF;
         3'h1:    sys_mask = 11'h3FF;
         3'h2:    sys_mask = 11'h0FF;
         3'h3:    sys_mask = 11'h03F;
         3'h4:    sys_mask = 11'h00F;
         3'h5:    sys_mask = 11'h003;
         3'h6:    sys_mask = 11'h001;
         default: sys_mask = 11'h000;
      endcase
   endfunction

   // Low-frequency divisions 2^4, 2^3, 2^2
   function automatic logic [LF_W-1:0] lf_mask(input logic [2:0] c);
      case (c)
         3'h0:    lf_mask = 4'hF;
         3'h1:    lf_mask = 4'h7;
         default: lf_mask = 4'h3;
      endcase
   endfunction

   // Free-running dividers; the counter itself never resets them
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         presc_q <= '0;
         lf_q    <= '0;
      end else begin
         presc_q <= presc_q + 1'b1;
         if (lf_edge) begin
            lf_q <= lf_q + 1'b1;
         end
      end
   end

   // Code 111 stays the undivided system clock unless in slow mode
   assign lf_code  = (clock_select_field == 3'h0) ||
                     (clock_select_field == 3'h1) ||
                     (slow_mode && clock_select_field == 3'h7);
   assign sys_tick = (presc_q & sys_mask(clock_select_field)) ==
                     sys_mask(clock_select_field);
   assign lf_tick  = lf_edge && ((lf_q & lf_mask(clock_select_field)) ==
                     lf_mask(clock_select_field));

   // Pick the source; slow mode has no system-clock codes
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_q <= 1'b0;
      end else if (external_input_select) begin
         tick_q <= ext_edge;
      end else if ((prescaler_source_bit || slow_mode) && lf_code) begin
         tick_q <= lf_tick;
      end else if (slow_mode) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= sys_tick;
      end
   end

endmodule
`default_nettype wire

// *** verilog/ppg_timer.sv ***
// Cascaded 16-bit pulse generator with AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Cascade bit joins both timers; only high-timer settings count.
// - Mode field 11 with cascade selects pulse generation.
// - External-input bit picks the clock pin, else the internal divider.
// - Clock-select codes pick system divisions; low-frequency codes replace codes 0 and 1, and also 7 in slow mode.
// - Double-buffer bit routes committed compare values through the buffer.
// - High and low registers form 16-bit period and duty values.
// - Writing duty high commits all four registers together.
// - Initial-level bit sets the output level before counting.
// - Stopped timer with pin function drives the initial level.
// - Run bit set makes the counter step on each source tick.
// - Duty match inverts output and raises the low-timer request.
// - Period match restores level, raises high request, clears counter.
// - Clearing run stops and clears counter, restores initial level.
// - Buffered values load on next period match while running.
// - A commit while stopped updates buffer and active values at once.
// - Compare values below the count wait for wrap before matching.
// - Timer registers read back the last written values.
module ppg_timer
   import ppg_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // AXI4-Lite write address and data
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   // AXI4-Lite write response
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // AXI4-Lite read
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // Clock pins
   input  wire logic              ext_clk_pin,
   input  wire logic              low_freq_clk,
   // Pulse pin and requests
   output logic                   pulse_output_pin,
   output logic                   pulse_output_oe,
   output logic                   low_timer_interrupt,
   output logic                   high_timer_interrupt
);

   logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q, wdata_q;
   logic [3:0]        wstrb_q;
   logic [ADDR_W-1:0] waddr_q;
   logic              aw_got_q, w_got_q, do_write, commit;
   ctrl_type          ctrl_q;
   mode_type          mode_q;
   logic [7:0]        per_lo_q, per_hi_q, duty_lo_q, duty_hi_q;
   compare_type       new_cmp, buf_q, act_q;
   logic [15:0]       count_q;
   logic              level_q, oe_q, lo_irq_q, hi_irq_q;
   logic              ppg_on, tick, lf_edge, ext_edge, per_hit, duty_hit;

   // Mapped, word-aligned register addresses
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      case (a)
         CTRL_OFS, MODE_OFS, PER_LO_OFS, PER_HI_OFS,
         DUTY_LO_OFS, DUTY_HI_OFS, STAT_OFS: reg_hit = 1'b1;
         default:                            reg_hit = 1'b0;
      endcase
   endfunction

   // Byte-lane merge for narrow registers
   function automatic logic [7:0] lane(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic       en);
      lane = en ? nw : old;
   endfunction

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Address and data are taken in either order, one write at a time
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awready_q <= 1'b0;
         aw_got_q  <= 1'b0;
         waddr_q   <= '0;
      end else if (awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_got_q  <= 1'b1;
         waddr_q   <= awaddr;
      end else begin
         if (do_write) begin
            aw_got_q <= 1'b0;
         end
         awready_q <= !aw_got_q && !bvalid_q;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wready_q <= 1'b0;
         w_got_q  <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_got_q  <= 1'b1;
         wdata_q  <= wdata;
         wstrb_q  <= wstrb;
      end else begin
         if (do_write) begin
            w_got_q <= 1'b0;
         end
         wready_q <= !w_got_q && !bvalid_q;
      end
   end

   assign do_write = aw_got_q && w_got_q && !bvalid_q;

   // Response one cycle after both halves are held
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= reg_hit(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read answer; unmapped offsets give zero with an error
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            CTRL_OFS:    rdata_q <= {29'h0, ctrl_q};
            MODE_OFS:    rdata_q <= {22'h0, mode_q};
            PER_LO_OFS:  rdata_q <= {24'h0, per_lo_q};
            PER_HI_OFS:  rdata_q <= {24'h0, per_hi_q};
            DUTY_LO_OFS: rdata_q <= {24'h0, duty_lo_q};
            DUTY_HI_OFS: rdata_q <= {24'h0, duty_hi_q};
            STAT_OFS:    rdata_q <= {15'h0, level_q, count_q};
            default:     rdata_q <= '0;
         endcase
      end else if (rvalid_q) begin
         if (rready) begin
            rvalid_q <= 1'b0;
         end
      end else begin
         arready_q <= 1'b1;
      end
   end

   // Control and mode registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         mode_q <= MODE_RST;
      end else if (do_write) begin
         if (waddr_q == CTRL_OFS && wstrb_q[0]) begin
            ctrl_q <= wdata_q[CTRL_W-1:0];
         end
         if (waddr_q == MODE_OFS) begin
            mode_q <= mode_type'(MODE_W'(
                         {lane({6'h0, mode_q[MODE_W-1:8]}, wdata_q[15:8],
                               wstrb_q[1]),
                          lane(mode_q[7:0], wdata_q[7:0], wstrb_q[0])}));
         end
      end
   end

   // Timer registers keep what software wrote, for readback
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         per_lo_q  <= TIMER_RST;
         per_hi_q  <= TIMER_RST;
         duty_lo_q <= TIMER_RST;
         duty_hi_q <= TIMER_RST;
      end else if (do_write) begin
         if (waddr_q == PER_LO_OFS) begin
            per_lo_q <= lane(per_lo_q, wdata_q[7:0], wstrb_q[0]);
         end
         if (waddr_q == PER_HI_OFS) begin
            per_hi_q <= lane(per_hi_q, wdata_q[7:0], wstrb_q[0]);
         end
         if (waddr_q == DUTY_LO_OFS) begin
            duty_lo_q <= lane(duty_lo_q, wdata_q[7:0], wstrb_q[0]);
         end
         if (commit) begin
            duty_hi_q <= wdata_q[7:0];
         end
      end
   end

   // Only a duty-high write moves the staged values onward
   assign commit  = do_write && waddr_q == DUTY_HI_OFS && wstrb_q[0];
   assign new_cmp = {per_hi_q, per_lo_q, wdata_q[7:0], duty_lo_q};

   // Cascade, pair run and PPG mode must all hold to count
   assign ppg_on = ctrl_q.cascade_enable &&
                   mode_q.mode_field == MODE_PPG &&
                   ctrl_q.run_bit;
   // Equality only, so a value already passed waits for the wrap
   assign per_hit  = ppg_on && tick && count_q == act_q.period_value;
   assign duty_hit = ppg_on && tick && count_q == act_q.duty_value;

   // Buffer and active compare values
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_q <= CMP_RST;
         act_q <= CMP_RST;
      end else if (commit) begin
         buf_q <= new_cmp;
         if (!ppg_on || !mode_q.double_buffer_enable) begin
            act_q <= new_cmp;
         end
      end else if (per_hit && mode_q.double_buffer_enable) begin
         act_q <= buf_q;
      end
   end

   // Up counter; any stop condition clears it at once
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_q <= COUNT_ZERO;
      end else if (!ppg_on) begin
         count_q <= COUNT_ZERO;
      end else if (per_hit) begin
         count_q <= COUNT_ZERO;
      end else if (tick) begin
         count_q <= count_q + 1'b1;
      end
   end

   // Output level; period match wins when both match together
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_q <= MODE_RST.initial_level_bit;
      end else if (!ppg_on || per_hit) begin
         level_q <= mode_q.initial_level_bit;
      end else if (duty_hit) begin
         level_q <= ~mode_q.initial_level_bit;
      end
   end

   // Request pulses and pin enable
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lo_irq_q <= 1'b0;
         hi_irq_q <= 1'b0;
         oe_q     <= 1'b0;
      end else begin
         lo_irq_q <= duty_hit;
         hi_irq_q <= per_hit;
         oe_q     <= ctrl_q.pin_function;
      end
   end

   assign pulse_output_pin     = level_q;
   assign pulse_output_oe      = oe_q;
   assign low_timer_interrupt  = lo_irq_q;
   assign high_timer_interrupt = hi_irq_q;

   // Clock pins cross into the system domain here
   edge_sync u_ext_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (ext_clk_pin),
      .rise_q   (ext_edge)
   );

   edge_sync u_lf_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (low_freq_clk),
      .rise_q   (lf_edge)
   );

   tick_source u_tick (
      .sys_clk               (sys_clk),
      .rst                   (rst),
      .clock_select_field    (mode_q.clock_select_field),
      .external_input_select (mode_q.external_input_select),
      .prescaler_source_bit  (mode_q.prescaler_source_bit),
      .slow_mode             (mode_q.slow_mode),
      .lf_edge               (lf_edge),
      .ext_edge              (ext_edge),
      .tick_q                (tick)
   );

   // Checks on the counting core
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_no_cascade;
      !ctrl_q.cascade_enable |=> count_q == COUNT_ZERO && !hi_irq_q;
   endproperty
   a_no_cascade: assert property (p_no_cascade)
      else $error("counter moved without cascade");

   property p_mode_gate;
      mode_q.mode_field != MODE_PPG |=> count_q == COUNT_ZERO;
   endproperty
   a_mode_gate: assert property (p_mode_gate)
      else $error("counter moved outside PPG mode");

   property p_step;
      ppg_on && tick && !per_hit |=> count_q == $past(count_q) + 16'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step on tick");

   property p_duty;
      duty_hit && !per_hit |=>
         level_q == !$past(mode_q.initial_level_bit) && lo_irq_q;
   endproperty
   a_duty: assert property (p_duty)
      else $error("duty match did not invert output");

   property p_period;
      per_hit |=> count_q == COUNT_ZERO && hi_irq_q &&
                  level_q == $past(mode_q.initial_level_bit);
   endproperty
   a_period: assert property (p_period)
      else $error("period match did not restart");

   property p_stop;
      $fell(ctrl_q.run_bit) |=> count_q == COUNT_ZERO &&
         level_q == $past(mode_q.initial_level_bit);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not clear counter");

   property p_idle_level;
      !ppg_on ##1 !ppg_on |-> level_q == $past(mode_q.initial_level_bit);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle output not at initial level");

   property p_direct;
      commit && (!ppg_on || !mode_q.double_buffer_enable) |=>
         act_q == $past(new_cmp) && buf_q == $past(new_cmp);
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct commit not applied");

   property p_buffered;
      commit && ppg_on && mode_q.double_buffer_enable |=>
         act_q == $past(act_q) && buf_q == $past(new_cmp);
   endproperty
   a_buffered: assert property (p_buffered)
      else $error("buffered commit applied early");

   c_duty: cover property (duty_hit);
   c_period: cover property (per_hit && mode_q.double_buffer_enable);
   c_stop: cover property ($fell(ctrl_q.run_bit) && count_q != COUNT_ZERO);

endmodule
`default_nettype wire

// *** sim/ppg_load.sv ***
// Load on the pulse pin and source of the two clock pins
`timescale 1ns/1ps
`default_nettype none
module ppg_load (
   // Pulse pin from the timer
   input  wire logic pulse_output_pin,
   input  wire logic pulse_output_oe,
   // External clock request from the bench
   input  wire logic ext_run,
   // Clock pins and sensed line level
   output logic      ext_clk_pin,
   output logic      low_freq_clk,
   output logic      pin_level
);
   // Weak pull-down holds the line while the pin floats
   assign pin_level = pulse_output_oe ? pulse_output_pin : 1'b0;

   // Slow clock runs free, 64 ns period
   initial begin
      low_freq_clk = 1'b0;
      forever #32 low_freq_clk = ~low_freq_clk;
   end

   // Four-cycle phases keep it well under half rate
   initial begin
      ext_clk_pin = 1'b0;
      forever begin
         #16;
         ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** sim/test_ppg_timer.sv ***
// Self-checking bench for the cascaded pulse generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
   end \
end
module test_ppg_timer import ppg_pkg::*;;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, ext_run = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        ext_clk_pin, low_freq_clk, pin_level;
   logic        pulse_output_pin, pulse_output_oe;
   logic        low_timer_interrupt, high_timer_interrupt;
   logic [33:0] expect_q[$];
   logic [33:0] note;
   int          fail_count = 0, comparisons = 0, cyc = 0, t0, t1, t2;
   int          shifts[8] = '{11, 10, 8, 6, 4, 2, 1, 0};

   ppg_timer DUT (.sys_clk(sys_clk), .rst(rst), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .ext_clk_pin(ext_clk_pin), .low_freq_clk(low_freq_clk),
      .pulse_output_pin(pulse_output_pin), .pulse_output_oe(pulse_output_oe),
      .low_timer_interrupt(low_timer_interrupt),
      .high_timer_interrupt(high_timer_interrupt));
   ppg_load load (.pulse_output_pin(pulse_output_pin),
      .pulse_output_oe(pulse_output_oe), .ext_run(ext_run),
      .ext_clk_pin(ext_clk_pin), .low_freq_clk(low_freq_clk),
      .pin_level(pin_level));

   // 250 MHz clock and a cycle count for intervals
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;

   // Oldest note meets each bus answer
   always @(posedge sys_clk) begin
      if (bvalid && bready) begin
         note = expect_q.pop_front();
         `CHK({bresp, 32'h0}, note)
      end
      if (rvalid && rready) begin
         note = expect_q.pop_front();
         `CHK({rresp, rdata}, note)
      end
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic timeout();
      fail_count++;
      tally_and_finish();
   endtask

   // Write with both channels offered together; waits for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      expect_q.push_back({r, 32'h0});
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 100) timeout();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      expect_q.push_back({r, d});
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 100) timeout();
   endtask

   // Next period match; pin level checked at both requests
   task automatic wait_hi(input logic lvl, output int t);
      int n;
      for (n = 0; n < 20000; n++) begin
         @(posedge sys_clk);
         if (low_timer_interrupt) `CHK(pulse_output_pin, ~lvl)
         if (high_timer_interrupt) break;
      end
      t = cyc;
      `CHK(pulse_output_pin, lvl)
      if (n == 20000) timeout();
   endtask

   // Three registers first, duty high last commits
   task automatic prog(input logic [15:0] p, input logic [15:0] du);
      wr(PER_LO_OFS, {24'h0, p[7:0]}, RESP_OKAY);
      wr(PER_HI_OFS, {24'h0, p[15:8]}, RESP_OKAY);
      wr(DUTY_LO_OFS, {24'h0, du[7:0]}, RESP_OKAY);
      wr(DUTY_HI_OFS, {24'h0, du[15:8]}, RESP_OKAY);
   endtask

   task automatic cfg(input logic [2:0] c, input logic e, input logic [1:0] ps,
                      input logic il, input logic db);
      mode_type m;
      m = MODE_RST;
      m.mode_field = MODE_PPG;
      m.clock_select_field = c;
      m.external_input_select = e;
      m.prescaler_source_bit = ps[0];
      m.slow_mode = ps[1];
      m.initial_level_bit = il;
      m.double_buffer_enable = db;
      wr(CTRL_OFS, 32'h4, RESP_OKAY);
      wr(MODE_OFS, 32'(m), RESP_OKAY);
   endtask

   // One source clock setting: two period matches, then stop
   task automatic run_case(input logic [2:0] c, input logic e,
                           input logic [1:0] ps, input logic il, input int dv);
      logic [15:0] p;
      logic [15:0] du;
      p = 16'(2 + $urandom % 3);
      du = 16'($urandom % p);
      ext_run <= e;
      cfg(c, e, ps, il, 1'b1);
      prog(p, du);
      `CHK(pin_level, il)
      wr(CTRL_OFS, 32'h7, RESP_OKAY);
      wait_hi(il, t0);
      wait_hi(il, t1);
      `CHK(t1 - t0, 32'((p + 1) * dv))
      wr(CTRL_OFS, 32'h5, RESP_OKAY);
      rd(STAT_OFS, {15'h0, il, 16'h0}, RESP_OKAY);
   endtask

   initial begin
      void'($urandom(6760));
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      `CHK(pin_level, 1'b0)
      for (int a = 8; a <= 20; a += 4) rd(8'(a), 32'hFF, RESP_OKAY);
      rd(CTRL_OFS, 32'h0, RESP_OKAY);
      rd(STAT_OFS, 32'h0, RESP_OKAY);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      wr(8'h1C, 32'h0, RESP_SLVERR);
      for (int k = 0; k < 8; k++) run_case(3'(k), 1'b0, 2'h0, k[0],
         1 << shifts[k]);
      run_case(3'h7, 1'b1, 2'h0, 1'b1, 8);
      run_case(3'h7, 1'b0, 2'h1, 1'b0, 1);
      run_case(3'h7, 1'b0, 2'h2, 1'b0, 64);
      run_case(3'h0, 1'b0, 2'h1, 1'b1, 256);
      // Buffered commit mid-run keeps the old period once
      cfg(3'h4, 1'b0, 2'h0, 1'b0, 1'b1);
      prog(16'h3, 16'h1);
      wr(CTRL_OFS, 32'h7, RESP_OKAY);
      wait_hi(1'b0, t0);
      prog(16'h5, 16'h2);
      wait_hi(1'b0, t1);
      wait_hi(1'b0, t2);
      `CHK(t1 - t0, 64)
      `CHK(t2 - t1, 96)
      rd(PER_LO_OFS, 32'h5, RESP_OKAY);
      // Unbuffered commit mid-run shortens the current period
      wr(MODE_OFS, 32'h23, RESP_OKAY);
      wait_hi(1'b0, t0);
      prog(16'h3, 16'h1);
      wait_hi(1'b0, t1);
      `CHK(t1 - t0, 64)
      // No counting without cascade, nor outside the pulse mode
      wr(CTRL_OFS, 32'h6, RESP_OKAY);
      repeat (40) @(posedge sys_clk);
      rd(STAT_OFS, 32'h0, RESP_OKAY);
      wr(MODE_OFS, 32'h2, RESP_OKAY);
      wr(CTRL_OFS, 32'h7, RESP_OKAY);
      repeat (40) @(posedge sys_clk);
      rd(STAT_OFS, 32'h0, RESP_OKAY);
      tally_and_finish();
   end
endmodule
`default_nettype wire
